// File: design/sec_map.svh
// constant map of the serial nonvolatile memory command core
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH
`define SEC_OP_READ         8'h03
`define SEC_OP_WRITE        8'h02
`define SEC_OP_LATCH_SET    8'h06
`define SEC_OP_LATCH_CLEAR  8'h04
`define SEC_OP_SR_READ      8'h05
`define SEC_OP_SR_WRITE     8'h01
`define SEC_OP_PAGE_CLEAR   8'h42
`define SEC_OP_REGION_CLEAR 8'hD8
`define SEC_OP_ALL_CLEAR    8'hC7
`define SEC_OP_WAKE_SIG     8'hAB
`define SEC_OP_SLEEP        8'hB9
`define SEC_ADDR_W          17
`define SEC_PAGE_W          8
`define SEC_SECTOR_W        15
`define SEC_ADDR_BYTES      2'h2
`define SEC_LAST_BIT        3'h7
`define SEC_SR_GATE         7
`define SEC_SR_LVL_HI       3
`define SEC_SR_LVL_LO       2
`define SEC_SR_WEL          1
`define SEC_SR_BUSY         0
`define SEC_FILL            8'hFF
`define SEC_QTR_BASE        17'h1_8000
`define SEC_HALF_BASE       17'h1_0000
`define SEC_PINS_IDLE       5'h13
`define SEC_CLK_KHZ         50000
`define SEC_T_WRITE_MS      6
`define SEC_T_ERASE_MS      10
`define SEC_WRITE_CYC       (`SEC_T_WRITE_MS * `SEC_CLK_KHZ)
`define SEC_ERASE_CYC       (`SEC_T_ERASE_MS * `SEC_CLK_KHZ)
`define SEC_SIGNATURE       8'h5A
`endif

// File: design/sec_pkg.sv
// types shared by the serial nonvolatile memory command core
package sec_pkg;
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} sec_pins_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_OPC,
		ST_ADDR,
		ST_RDATA,
		ST_WDATA,
		ST_STAT,
		ST_STWR,
		ST_SIG,
		ST_END,
		ST_IGNORE
	} sec_state_t;
endpackage : sec_pkg

// File: design/sec_top.sv
// serial command front end with array, status register and self-timed write engine
`include "sec_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - eight-bit instruction shifted in on serial clock rises after select falls
// - opcodes, addresses and data move most significant bit first
// - pause freezes the transfer; release resumes exactly where it stood
// - opcode 03h reads memory, 02h writes memory, from following address
// - opcode 06h sets write enable latch, 04h clears it
// - opcode 05h returns status byte, 01h writes status byte
// - opcode 42h page clear, D8h sector clear, C7h whole array clear
// - opcode ABh wakes and returns signature, B9h enters sleep
// - read takes 24 address bits, top seven ignored, then shifts data
// - read pointer advances per byte, wraps 1FFFFh to 0, ends on select rise
// - latch set only counts if select rises right after its eighth bit
// - write: 24-bit address, top seven ignored, then 1 to 256 bytes
// - write data past page end wraps to the start of that page
// - write cycle starts only if select rises right after last D0
// - array reads refused while busy, status read allowed while busy but refused while sleeping
// - write enable latch clears when the internal cycle ends
// - latch clears at reset, after clear, and after accepted status, write, erase commands
// - status: gate bit7, level bits 3:2, latch bit1, busy bit0
// - busy bit reads one during a write, status write or erase cycle, zero otherwise
// - latch set and clear work whatever the protection state
// - protect level bits change only through status write
// - level 00 none, 01 18000h up, 10 10000h up, 11 whole array
// - after reset deselected, latch clear, output released, needs select fall
module sec_top #(
	parameter int        ADDR_W       = `SEC_ADDR_W,
	parameter int        PAGE_W       = `SEC_PAGE_W,
	parameter int        SECTOR_W     = `SEC_SECTOR_W,
	parameter int        TIMER_W      = 20,
	parameter int        WRITE_CYCLES = `SEC_WRITE_CYC,
	parameter int        ERASE_CYCLES = `SEC_ERASE_CYC,
	// signature value is arbitrary
	parameter logic [7:0] SIGNATURE   = `SEC_SIGNATURE
) (
	input  wire logic CLK_SYS_I,
	input  wire logic RST_N_I,
	input  wire logic CS_N_I,
	input  wire logic SCK_I,
	input  wire logic SI_I,
	input  wire logic HOLD_N_I,
	input  wire logic WP_N_I,
	output var  logic SO_O,
	output var  logic SO_OE_O
);
	import sec_pkg::*;

	logic [1:0]         rst_sync;
	logic               rst_n;
	sec_pins_t          pin_raw;
	sec_pins_t          pin_meta;
	sec_pins_t          pin_s;
	sec_pins_t          pin_d;
	logic               sel;
	logic               active;
	logic               sck_rise;
	logic               sck_fall;
	logic               cs_rise;
	logic               byte_done;
	logic [7:0]         rx_byte;
	sec_state_t         state;
	logic [2:0]         bitcnt;
	logic [7:0]         shreg;
	logic [7:0]         opcode;
	logic [23:0]        addr_acc;
	logic [1:0]         addr_cnt;
	logic [ADDR_W-1:0]  ptr;
	logic [ADDR_W-1:0]  next_addr;
	logic [7:0]         out_byte;
	logic               out_live;
	logic               wbytes_any;
	logic [7:0]         sr_data;
	logic [7:0]         status;
	logic               gate;
	logic [1:0]         level;
	logic               write_enable_latch;
	logic               busy;
	logic               sleeping;
	logic [TIMER_W-1:0] timer;
	logic               sweeping;
	logic               sweep_fill;
	logic [ADDR_W-1:0]  sweep_ptr;
	logic [ADDR_W-1:0]  sweep_last;
	logic               wp_block;
	logic               clean_end;
	logic [ADDR_W-1:0]  page_base;
	logic [ADDR_W-1:0]  sector_base;
	logic [7:0]         mem [0:(1<<ADDR_W)-1];
	logic [7:0]         pbuf [0:(1<<PAGE_W)-1];
	logic [(1<<PAGE_W)-1:0] pmask;

	function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] lvl);
		unique case (lvl)
			2'h0: is_protected = 1'b0;
			2'h1: is_protected = (a >= ADDR_W'(`SEC_QTR_BASE));
			2'h2: is_protected = (a >= ADDR_W'(`SEC_HALF_BASE));
			2'h3: is_protected = 1'b1;
		endcase
	endfunction : is_protected

	function automatic logic is_out_state(input sec_state_t s);
		is_out_state = (s == ST_RDATA) || (s == ST_STAT) || (s == ST_SIG);
	endfunction : is_out_state

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// pins come from the host's domain; two stages, then a third copy for edges
	assign pin_raw = {CS_N_I, SCK_I, SI_I, HOLD_N_I, WP_N_I};
	always_ff @(posedge CLK_SYS_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta <= `SEC_PINS_IDLE;
			pin_s    <= `SEC_PINS_IDLE;
			pin_d    <= `SEC_PINS_IDLE;
		end
		else
		begin
			pin_meta <= pin_raw;
			pin_s    <= pin_meta;
			pin_d    <= pin_s;
		end
	end

	assign sel       = ~pin_s.cs_n;
	assign active    = sel & pin_s.hold_n;
	assign sck_rise  = active & pin_s.sck & ~pin_d.sck;
	assign sck_fall  = active & ~pin_s.sck & pin_d.sck;
	assign cs_rise   = pin_s.cs_n & ~pin_d.cs_n;
	assign rx_byte   = {shreg[6:0], pin_s.si};
	assign byte_done = sck_rise && (bitcnt == `SEC_LAST_BIT);
	// upper address bits fall off the accumulator here
	assign next_addr = {addr_acc[ADDR_W-9:0], rx_byte};
	assign page_base   = {ptr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
	assign sector_base = {ptr[ADDR_W-1:SECTOR_W], {SECTOR_W{1'b0}}};
	assign wp_block    = gate & ~pin_s.wp_n;
	assign clean_end   = cs_rise && (state == ST_END) && (bitcnt == 3'h0);

	always_comb
	begin
		status                = 8'h00;
		status[`SEC_SR_GATE]   = gate;
		status[`SEC_SR_LVL_HI] = level[1];
		status[`SEC_SR_LVL_LO] = level[0];
		status[`SEC_SR_WEL]    = write_enable_latch;
		status[`SEC_SR_BUSY]   = busy;
	end

	// command sequencer
	always_ff @(posedge CLK_SYS_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state    <= ST_IDLE;
			bitcnt   <= 3'h0;
			shreg    <= 8'h00;
			opcode   <= 8'h00;
			addr_acc <= 24'h00_0000;
			addr_cnt <= 2'h0;
			ptr      <= '0;
			out_byte <= 8'h00;
			sr_data  <= 8'h00;
		end
		else if (pin_s.cs_n)
		begin
			state  <= ST_IDLE;
			bitcnt <= 3'h0;
		end
		else if (state == ST_IDLE)
			state <= ST_OPC;
		else if (sck_rise)
		begin
			bitcnt <= bitcnt + 3'h1;
			shreg  <= rx_byte;
			if (state == ST_END)
				state <= ST_IGNORE;
			else if (byte_done)
			begin
				unique case (state)
					ST_OPC:
					begin
						opcode   <= rx_byte;
						addr_cnt <= 2'h0;
						if (sleeping && rx_byte != `SEC_OP_WAKE_SIG)
							state <= ST_IGNORE;
						else if (busy && rx_byte != `SEC_OP_SR_READ)
							state <= ST_IGNORE;
						else
						begin
							unique case (rx_byte)
								`SEC_OP_READ, `SEC_OP_WRITE, `SEC_OP_PAGE_CLEAR,
								`SEC_OP_REGION_CLEAR, `SEC_OP_WAKE_SIG:
									state <= ST_ADDR;
								`SEC_OP_LATCH_SET, `SEC_OP_LATCH_CLEAR,
								`SEC_OP_ALL_CLEAR, `SEC_OP_SLEEP:
									state <= ST_END;
								`SEC_OP_SR_READ:
								begin
									state    <= ST_STAT;
									out_byte <= status;
								end
								`SEC_OP_SR_WRITE:
									state <= ST_STWR;
								default:
									state <= ST_IGNORE;
							endcase
						end
					end
					ST_ADDR:
					begin
						addr_acc <= {addr_acc[15:0], rx_byte};
						addr_cnt <= addr_cnt + 2'h1;
						if (addr_cnt == `SEC_ADDR_BYTES)
						begin
							ptr <= next_addr;
							unique case (opcode)
								`SEC_OP_READ:
								begin
									state    <= ST_RDATA;
									out_byte <= mem[next_addr];
									ptr      <= next_addr + ADDR_W'(1);
								end
								`SEC_OP_WRITE:
									state <= ST_WDATA;
								`SEC_OP_WAKE_SIG:
								begin
									state    <= ST_SIG;
									out_byte <= SIGNATURE;
								end
								default:
									state <= ST_END;
							endcase
						end
					end
					ST_RDATA:
					begin
						out_byte <= mem[ptr];
						ptr      <= ptr + ADDR_W'(1);
					end
					ST_WDATA:
						ptr[PAGE_W-1:0] <= ptr[PAGE_W-1:0] + PAGE_W'(1);
					ST_STAT:
						out_byte <= status;
					ST_SIG:
						out_byte <= SIGNATURE;
					ST_STWR:
					begin
						sr_data <= rx_byte;
						state   <= ST_END;
					end
					default:
						state <= ST_IGNORE;
				endcase
			end
		end
	end

	// page buffer collects write data; the array only changes after a clean end
	always_ff @(posedge CLK_SYS_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pmask      <= '0;
			wbytes_any <= 1'b0;
		end
		else if (byte_done && state == ST_OPC && !busy)
		begin
			// a status poll during the sweep must not wipe the marks
			pmask      <= '0;
			wbytes_any <= 1'b0;
		end
		else if (byte_done && state == ST_WDATA)
		begin
			pmask[ptr[PAGE_W-1:0]] <= 1'b1;
			wbytes_any             <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (byte_done && state == ST_WDATA)
			pbuf[ptr[PAGE_W-1:0]] <= rx_byte;
	end

	// commit, latch and self-timed cycle control
	always_ff @(posedge CLK_SYS_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			write_enable_latch        <= 1'b0;
			gate       <= 1'b0;
			level      <= 2'h0;
			busy       <= 1'b0;
			sleeping   <= 1'b0;
			timer      <= '0;
			sweeping   <= 1'b0;
			sweep_fill <= 1'b0;
			sweep_ptr  <= '0;
			sweep_last <= '0;
		end
		else if (busy)
		begin
			if (timer != '0)
				timer <= timer - TIMER_W'(1);
			if (sweeping)
			begin
				sweep_ptr <= sweep_ptr + ADDR_W'(1);
				if (sweep_ptr == sweep_last)
					sweeping <= 1'b0;
			end
			if (timer == '0 && !sweeping)
			begin
				busy <= 1'b0;
				write_enable_latch  <= 1'b0;
			end
		end
		else if (byte_done && state == ST_OPC && rx_byte == `SEC_OP_WAKE_SIG)
			sleeping <= 1'b0;
		else if (clean_end)
		begin
			unique case (opcode)
				`SEC_OP_LATCH_SET:
					write_enable_latch <= 1'b1;
				`SEC_OP_LATCH_CLEAR:
					write_enable_latch <= 1'b0;
				`SEC_OP_SLEEP:
					sleeping <= 1'b1;
				`SEC_OP_SR_WRITE:
				begin
					if (write_enable_latch && !wp_block)
					begin
						gate  <= sr_data[`SEC_SR_GATE];
						level <= {sr_data[`SEC_SR_LVL_HI], sr_data[`SEC_SR_LVL_LO]};
						busy  <= 1'b1;
						timer <= TIMER_W'(WRITE_CYCLES);
					end
				end
				`SEC_OP_PAGE_CLEAR:
				begin
					if (write_enable_latch && !is_protected(ptr, level))
					begin
						busy       <= 1'b1;
						timer      <= TIMER_W'(WRITE_CYCLES);
						sweeping   <= 1'b1;
						sweep_fill <= 1'b1;
						sweep_ptr  <= page_base;
						sweep_last <= page_base | ADDR_W'((1 << PAGE_W) - 1);
					end
				end
				`SEC_OP_REGION_CLEAR:
				begin
					if (write_enable_latch && !is_protected(ptr, level))
					begin
						busy       <= 1'b1;
						timer      <= TIMER_W'(ERASE_CYCLES);
						sweeping   <= 1'b1;
						sweep_fill <= 1'b1;
						sweep_ptr  <= sector_base;
						sweep_last <= sector_base | ADDR_W'((1 << SECTOR_W) - 1);
					end
				end
				`SEC_OP_ALL_CLEAR:
				begin
					if (write_enable_latch && level == 2'h0)
					begin
						busy       <= 1'b1;
						timer      <= TIMER_W'(ERASE_CYCLES);
						sweeping   <= 1'b1;
						sweep_fill <= 1'b1;
						sweep_ptr  <= '0;
						sweep_last <= '1;
					end
				end
				default:
				begin
				end
			endcase
		end
		else if (cs_rise && state == ST_WDATA && bitcnt == 3'h0 && wbytes_any)
		begin
			// whole page swept; only bytes marked in the buffer are rewritten
			if (write_enable_latch && !is_protected(ptr, level))
			begin
				busy       <= 1'b1;
				timer      <= TIMER_W'(WRITE_CYCLES);
				sweeping   <= 1'b1;
				sweep_fill <= 1'b0;
				sweep_ptr  <= page_base;
				sweep_last <= page_base | ADDR_W'((1 << PAGE_W) - 1);
			end
		end
	end

	// array write port, driven only by the sweep while busy
	always_ff @(posedge CLK_SYS_I)
	begin
		if (sweeping)
		begin
			if (sweep_fill)
				mem[sweep_ptr] <= `SEC_FILL;
			else if (pmask[sweep_ptr[PAGE_W-1:0]])
				mem[sweep_ptr] <= pbuf[sweep_ptr[PAGE_W-1:0]];
		end
	end

	// serial output; released while deselected or paused
	always_ff @(posedge CLK_SYS_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			SO_O     <= 1'b0;
			SO_OE_O  <= 1'b0;
			out_live <= 1'b0;
		end
		else
		begin
			if (pin_s.cs_n)
				out_live <= 1'b0;
			else if (sck_fall && is_out_state(state))
			begin
				SO_O     <= out_byte[~bitcnt];
				out_live <= 1'b1;
			end
			SO_OE_O <= sel & pin_s.hold_n & out_live & is_out_state(state);
		end
	end
endmodule : sec_top

`default_nettype wire

// File: dv/sec_top_sva.sv
// pin-level assertions for the serial command core
`timescale 1ns/1ps
`default_nettype none
module sec_top_sva (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic CS_N_I,
	input wire logic SCK_I,
	input wire logic SI_I,
	input wire logic HOLD_N_I,
	input wire logic WP_N_I,
	input wire logic SO_O,
	input wire logic SO_OE_O
);
	logic       sck_q;
	logic [5:0] rises;
	logic [3:0] since_fall;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			sck_q <= 1'h0;
		else
			sck_q <= SCK_I;
	end
	// pin rises while selected and not paused; saturates
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rises <= 6'h0;
		else if (CS_N_I)
			rises <= 6'h0;
		else if (SCK_I && !sck_q && HOLD_N_I && rises != 6'h3F)
			rises <= rises + 6'h1;
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			since_fall <= 4'h0;
		else if (!SCK_I && sck_q)
			since_fall <= 4'h0;
		else if (since_fall != 4'hF)
			since_fall <= since_fall + 4'h1;
	end
	a_oe_needs_select: assert property ($rose(SO_OE_O) |-> !CS_N_I && HOLD_N_I)
		else $error("output enabled while deselected or paused");
	a_oe_after_opcode: assert property ($rose(SO_OE_O) |-> rises >= 6'h8)
		else $error("output enabled before a full opcode");
	a_oe_drop_deselect: assert property ($rose(CS_N_I) |-> ##[1:5] !SO_OE_O)
		else $error("output still driven after deselect");
	a_oe_drop_pause: assert property ($fell(HOLD_N_I) |-> ##[1:5] !SO_OE_O)
		else $error("output still driven during pause");
	a_idle_released: assert property (CS_N_I [*6] |-> !SO_OE_O)
		else $error("output driven while idle");
	a_so_quiet_high: assert property (SO_OE_O && SCK_I && $past(SCK_I) |-> $stable(SO_O))
		else $error("serial output moved while clock high");
	a_so_after_fall: assert property (SO_OE_O && $changed(SO_O) |-> since_fall <= 4'h6)
		else $error("serial output moved away from a clock fall");
	a_reset_released: assert property ($rose(RST_N_I) |-> !SO_OE_O [*3])
		else $error("output driven right after reset");
	cover property ($rose(SO_OE_O));
	cover property ($fell(HOLD_N_I) ##[1:40] $rose(HOLD_N_I));
	cover property ($rose(CS_N_I) && rises == 6'h8);
endmodule : sec_top_sva
bind sec_top sec_top_sva i_sec_top_sva (
	.CLK_SYS_I(CLK_SYS_I),
	.RST_N_I(RST_N_I),
	.CS_N_I(CS_N_I),
	.SCK_I(SCK_I),
	.SI_I(SI_I),
	.HOLD_N_I(HOLD_N_I),
	.WP_N_I(WP_N_I),
	.SO_O(SO_O),
	.SO_OE_O(SO_OE_O)
);
`default_nettype wire

// File: dv/sec_host.sv
// serial host model driving the command link, mode 0
`timescale 1ns/1ps
`default_nettype none
module sec_host (
	input  wire logic clk_i,
	input  wire logic so_i,
	output var  logic cs_n_o,
	output var  logic sck_o,
	output var  logic si_o,
	output var  logic hold_n_o
);
	logic [7:0] rx;
	initial
	begin
		cs_n_o = 1'h1;
		sck_o = 1'h0;
		si_o = 1'h1;
		hold_n_o = 1'h1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task automatic start();
		cs_n_o <= 1'h0;
		tick(4);
	endtask : start
	task automatic stop();
		tick(2);
		cs_n_o <= 1'h1;
		tick(8);
	endtask : stop
	// clock stands still between bits; pause before bit pz with ignored clocks
	task automatic xfer(input logic [7:0] tx, input int nb = 8, input int pz = -1);
		for (int i = 7; i > 7 - nb; i--)
		begin
			if (i == pz)
			begin
				tick(4);
				hold_n_o <= 1'h0;
				si_o <= ~tx[i];
				tick(4);
				repeat (2)
				begin
					sck_o <= 1'h1;
					tick(4);
					sck_o <= 1'h0;
					tick(4);
				end
				hold_n_o <= 1'h1;
			end
			si_o <= tx[i];
			tick(4);
			sck_o <= 1'h1;
			@(negedge clk_i);
			rx[i] = so_i;
			tick(4);
			sck_o <= 1'h0;
		end
	endtask : xfer
endmodule : sec_host
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the serial command core
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sec_pkg::*;
	localparam logic [7:0] SIG = 8'hA5; // arbitrary signature
	logic       clk, rst_n, wp_n, cs_n, sck, si, hold_n, so, so_oe, oe_seen;
	logic [7:0] sr;
	logic [23:0] a;
	int         n;
	logic [7:0] exp_mem [logic [16:0]];
	int         mismatches;
	int         cmp_count;
	// released line shows the inverse of its last value
	wire logic  so_line = so_oe ? so : ~so;
	sec_top #(.WRITE_CYCLES(400), .ERASE_CYCLES(400), .SIGNATURE(SIG)) i_sec_top (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCK_I(sck), .SI_I(si),
		.HOLD_N_I(hold_n), .WP_N_I(wp_n), .SO_O(so), .SO_OE_O(so_oe));
	sec_host i_sec_host (.clk_i(clk), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
		.hold_n_o(hold_n));
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (so_oe) oe_seen <= 1'h1;
	function automatic logic [7:0] sr_exp(logic g, logic [1:0] l, logic w, logic b);
		return {g, 3'h0, l, w, b};
	endfunction : sr_exp
	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		cmp_count++;
		if (seen !== expv)
		begin
			mismatches++;
			$display("ERROR %0t: got %h, expected %h", $time, seen, expv);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic op(input logic [7:0] c, input logic [23:0] ad = 0, input bit wa = 0);
		i_sec_host.start();
		i_sec_host.xfer(c);
		if (wa)
		begin
			i_sec_host.xfer(ad[23:16]);
			i_sec_host.xfer(ad[15:8]);
			i_sec_host.xfer(ad[7:0]);
		end
	endtask : op
	task automatic rd_sr();
		op(8'h05);
		i_sec_host.xfer(8'h00);
		sr = i_sec_host.rx;
		i_sec_host.stop();
	endtask : rd_sr
	task automatic cmd(input logic [7:0] c, input logic [23:0] ad = 0, input bit wa = 0);
		op(c, ad, wa);
		i_sec_host.stop();
	endtask : cmd
	// status write carries exactly one byte; more bits void it
	task automatic sr_wr(input logic [7:0] v);
		op(8'h01);
		i_sec_host.xfer(v);
		i_sec_host.stop();
	endtask : sr_wr
	task automatic wait_idle();
		rd_sr();
		for (int t = 0; t < 20 && sr[0] !== 1'h0; t++) rd_sr();
	endtask : wait_idle
	task automatic mem_wr(input logic [23:0] ad, input int cnt, input bit keep);
		logic [7:0] d;
		op(8'h02, ad, 1);
		for (int k = 0; k < cnt; k++)
		begin
			d = 8'($urandom);
			if (keep) exp_mem[{ad[16:8], ad[7:0] + 8'(k)}] = d;
			i_sec_host.xfer(d);
		end
		i_sec_host.stop();
	endtask : mem_wr
	task automatic mem_rd(input logic [23:0] ad, input int cnt, input bit live = 1);
		logic [16:0] p;
		op(8'h03, ad, 1);
		for (int k = 0; k < cnt; k++)
		begin
			p = ad[16:0] + 17'(k);
			i_sec_host.xfer(8'h00, 8, k == 1 ? 2 : -1);
			if (live && exp_mem.exists(p)) check(i_sec_host.rx, exp_mem[p]);
		end
		i_sec_host.stop();
	endtask : mem_rd
	initial
	begin
		#(20 * 90000);
		mismatches++;
		$display("ERROR %0t: watchdog expired", $time);
		tally_and_finish();
	end
	initial
	begin
		{rst_n, wp_n, oe_seen, mismatches, cmp_count} = 0;
		wp_n = 1'h1;
		void'($urandom(13039));
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (8) @(posedge clk);
		rd_sr();
		check(sr, sr_exp(0, 0, 0, 0));
		check({7'h0, so_oe}, 8'h00);
		$display("reset state done");
		cmd(8'h06);
		rd_sr();
		check(sr, sr_exp(0, 0, 1, 0));
		cmd(8'h04);
		rd_sr();
		check(sr, sr_exp(0, 0, 0, 0));
		op(8'h06);
		mem_wr(24'h0, 1, 0);
		rd_sr();
		check(sr, sr_exp(0, 0, 0, 0));
		$display("latch tests done");
		for (int r = 0; r < 2; r++)
		begin
			a = 24'($urandom) & 24'hFE_FFFF;
			a[7:0] = 8'hF0 | 8'($urandom % 16);
			n = 1 + $urandom % 24;
			cmd(8'h06);
			mem_wr(a, n, 1);
			rd_sr();
			check(sr, sr_exp(0, 0, 1, 1));
			oe_seen = 1'h0;
			mem_rd(a, 1, 0);
			check({7'h0, oe_seen}, 8'h00);
			wait_idle();
			check(sr, sr_exp(0, 0, 0, 0));
			mem_rd({a[23:8], 8'h00}, 8);
			mem_rd(a, 16);
		end
		cmd(8'h06);
		op(8'h02, a, 1);
		i_sec_host.xfer(~exp_mem[a[16:0]]);
		i_sec_host.xfer(8'h3C, 4);
		i_sec_host.stop();
		rd_sr();
		check(sr, sr_exp(0, 0, 1, 0));
		mem_rd(a, 1);
		cmd(8'h04);
		cmd(8'h06);
		mem_wr(24'h01_FFFF, 1, 1);
		wait_idle();
		cmd(8'h06);
		mem_wr(24'h0, 1, 1);
		wait_idle();
		mem_rd(24'hFE_FFFF, 2);
		$display("array tests done");
		cmd(8'h06);
		sr_wr(8'hFC);
		rd_sr();
		check(sr, sr_exp(1, 3, 1, 1));
		wait_idle();
		check(sr, sr_exp(1, 3, 0, 0));
		wp_n <= 1'h0;
		cmd(8'h06);
		mem_wr(24'h000100, 1, 0);
		cmd(8'h42, 24'h0, 1);
		cmd(8'hD8, 24'h0, 1);
		cmd(8'hC7);
		sr_wr(8'h00);
		rd_sr();
		check(sr, sr_exp(1, 3, 1, 0));
		wp_n <= 1'h1;
		sr_wr(8'h04);
		wait_idle();
		check(sr, sr_exp(0, 1, 0, 0));
		cmd(8'h06);
		mem_wr(24'h018000, 1, 0);
		rd_sr();
		check(sr, sr_exp(0, 1, 1, 0));
		cmd(8'h42, 24'h0, 1);
		rd_sr();
		check(sr, sr_exp(0, 1, 1, 1));
		wait_idle();
		check(sr, sr_exp(0, 1, 0, 0));
		for (int k = 0; k < 256; k++) exp_mem[17'(k)] = 8'hFF;
		mem_rd(24'h0, 2);
		$display("status and protection tests done");
		cmd(8'hB9);
		oe_seen = 1'h0;
		rd_sr();
		check({7'h0, oe_seen}, 8'h00);
		op(8'hAB, 24'h0, 1);
		repeat (2)
		begin
			i_sec_host.xfer(8'h00);
			check(i_sec_host.rx, SIG);
		end
		i_sec_host.stop();
		rd_sr();
		check(sr, sr_exp(0, 1, 0, 0));
		$display("sleep tests done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
